// ### core/gbsm_pkg.sv
// constants, state and register types for the gigabit ethernet receive sync machine
// assumes decoded code groups arrive on the recovered parallel clock, one per valid cycle
// Behaviour
// - three valid sync ordered sets acquire sync
// - four uncancelled errored groups while synced lose sync
// - four consecutive good groups decrement error count
// - comma pattern length selectable seven or ten
// - sync set is comma plus odd data
// - search starts only after digital reset release
// - sync output holds high until loss
package gbsm_pkg;

	localparam int CNT_W = 9;

	localparam logic [CNT_W-1:0] SETS_TO_SYNC    = 9'h003;
	localparam logic [CNT_W-1:0] ERRS_TO_LOSE    = 9'h004;
	localparam logic [CNT_W-1:0] GOOD_TO_FORGIVE = 9'h004;
	localparam logic [CNT_W-1:0] CNT_ZERO        = 9'h000;
	localparam logic [CNT_W-1:0] CNT_ONE         = 9'h001;

	// comma patterns, bit 9 is the first bit on the line
	localparam logic [9:0] COMMA10_POS = 10'h0FA;
	localparam logic [9:0] COMMA10_NEG = 10'h305;
	localparam logic [6:0] COMMA7_POS  = 7'h1F;
	localparam logic [6:0] COMMA7_NEG  = 7'h60;

	typedef enum logic [1:0] {
		ST_LOS,
		ST_CDET,
		ST_ACQ,
		ST_SYNC
	} gbsm_state_type;

	typedef struct packed {
		gbsm_state_type   state;
		logic [CNT_W-1:0] sets;
		logic [CNT_W-1:0] errs;
		logic [CNT_W-1:0] good;
		logic             last_even;
	} gbsm_regs_type;

	localparam gbsm_regs_type REGS_RESET = '{
		state:     ST_LOS,
		sets:      9'h000,
		errs:      9'h000,
		good:      9'h000,
		last_even: 1'b0
	};

endpackage

// ### core/gbsm_comma_detect.sv
// comma detector for one received 10-bit code group
// assumes the group is already word aligned; purely combinational
`timescale 1ns/1ps
module gbsm_comma_detect
	import gbsm_pkg::*;
(
	input  wire logic [9:0] raw_group,
	input  wire logic       pat_len_10,
	output logic            comma_hit
);

	// seven-bit mode looks at the leading comma bits only, either disparity
	always_comb begin
		if (pat_len_10) begin
			comma_hit = (raw_group == COMMA10_POS) || (raw_group == COMMA10_NEG);
		end else begin
			comma_hit = (raw_group[9:3] == COMMA7_POS) || (raw_group[9:3] == COMMA7_NEG);
		end
	end

endmodule

// ### core/gbsm_sync.sv
// receive lane synchronization state machine for gigabit ethernet mode
// assumes code groups, classification flags, mode and digital reset all come from
// logic on ref_clk, so none of them is resynchronised here
`timescale 1ns/1ps
module gbsm_sync
	import gbsm_pkg::*;
#(
	parameter logic [CNT_W-1:0] SETS_N = SETS_TO_SYNC,
	parameter logic [CNT_W-1:0] ERRS_N = ERRS_TO_LOSE,
	parameter logic [CNT_W-1:0] GOOD_N = GOOD_TO_FORGIVE
) (
	input  wire logic             ref_clk,
	input  wire logic             arst_n,
	input  wire logic             rx_digitalreset,
	input  wire logic             gbe_mode,
	input  wire logic             pat_len_10,
	input  wire logic             cg_valid,
	input  wire logic [9:0]       cg_raw,
	input  wire logic             cg_ctrl,
	input  wire logic             cg_code_err,
	output logic                  sync_acquired,
	output logic [CNT_W-1:0]      err_level
);

	gbsm_regs_type r_q;
	gbsm_regs_type r_d;
	logic          comma_hit;
	logic          is_comma;
	logic          grp_bad;
	logic          data_ok;
	logic          comma_ok;
	logic          held;

	gbsm_comma_detect u_comma (
		.raw_group  (cg_raw),
		.pat_len_10 (pat_len_10),
		.comma_hit  (comma_hit)
	);

	// a comma landing on an odd position is an error, which also restarts alignment
	assign is_comma = comma_hit && !cg_code_err;
	assign grp_bad  = cg_code_err || (is_comma && r_q.last_even);
	assign data_ok  = !cg_code_err && !cg_ctrl && !comma_hit;
	assign comma_ok = is_comma && !r_q.last_even;
	assign held     = rx_digitalreset || !gbe_mode;

	// next state; reset or mode off parks the machine so no search runs meanwhile
	always_comb begin
		r_d = r_q;
		if (held) begin
			r_d = REGS_RESET;
		end else if (cg_valid) begin
			r_d.last_even = is_comma ? 1'b1 : ~r_q.last_even;
			case (r_q.state)
				ST_LOS: begin
					if (is_comma) begin
						r_d.state = ST_CDET;
						r_d.sets  = CNT_ZERO;
						r_d.last_even = 1'b1;
					end
				end
				ST_CDET: begin
					// the group after a comma must be data or the search restarts from loss of sync
					if (data_ok) begin
						if (CNT_W'(r_q.sets + CNT_ONE) >= SETS_N) begin
							r_d.state = ST_SYNC;
							r_d.errs  = CNT_ZERO;
							r_d.good  = CNT_ZERO;
						end else begin
							r_d.state = ST_ACQ;
						end
						r_d.sets = CNT_W'(r_q.sets + CNT_ONE);
					end else begin
						r_d.state = ST_LOS;
					end
				end
				ST_ACQ: begin
					if (grp_bad) begin
						r_d.state = ST_LOS;
					end else if (comma_ok) begin
						r_d.state = ST_CDET;
					end
				end
				ST_SYNC: begin
					if (grp_bad) begin
						r_d.good = CNT_ZERO;
						r_d.errs = CNT_W'(r_q.errs + CNT_ONE);
						if (CNT_W'(r_q.errs + CNT_ONE) >= ERRS_N) begin
							r_d.state = ST_LOS;
							r_d.sets  = CNT_ZERO;
						end
					end else if (CNT_W'(r_q.good + CNT_ONE) >= GOOD_N) begin
						// forgiving at zero would wrap, so the count just restarts
						r_d.good = CNT_ZERO;
						if (r_q.errs != CNT_ZERO) begin
							r_d.errs = CNT_W'(r_q.errs - CNT_ONE);
						end
					end else begin
						r_d.good = CNT_W'(r_q.good + CNT_ONE);
					end
				end
				default: begin
					r_d = REGS_RESET;
				end
			endcase
		end
	end

	// single state register
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			r_q <= REGS_RESET;
		end else begin
			r_q <= r_d;
		end
	end

	// err_level straight from the error flops; sync_acquired is decoded from the state register
	assign sync_acquired = (r_q.state == ST_SYNC);
	assign err_level     = r_q.errs;

	// one good sync ordered set, comma then data, both accepted
	sequence s_set;
		(cg_valid && !held && is_comma) ##1 (cg_valid && !held && data_ok);
	endsequence

	sequence s_three_sets;
		s_set ##1 s_set ##1 s_set;
	endsequence

	property p_three_sets_sync;
		@(posedge ref_clk) disable iff (!arst_n)
		(r_q.state == ST_LOS) ##0 s_three_sets |=> sync_acquired;
	endproperty

	a_three_sets_sync: assert property (p_three_sets_sync)
		else $error("three sync sets did not acquire sync");

	a_rise_from_cdet: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(sync_acquired) |-> $past(r_q.state) == ST_CDET && $past(r_q.sets) == SETS_N - 9'h001)
		else $error("sync rose without the full set count");

	a_lose_on_errs: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(sync_acquired && cg_valid && !held && grp_bad && r_q.errs == ERRS_N - 9'h001)
		|=> !sync_acquired)
		else $error("sync kept after the last allowed error");

	a_forgive_step: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(sync_acquired && cg_valid && !held && !grp_bad && r_q.good == GOOD_N - 9'h001
		 && r_q.errs != CNT_ZERO) |=> err_level == $past(r_q.errs) - 9'h001)
		else $error("good run did not reduce the error count");

	a_pattern_len: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(pat_len_10 && cg_raw[9:3] == COMMA7_POS && cg_raw[2:0] != COMMA10_POS[2:0])
		|-> !comma_hit)
		else $error("ten bit mode matched a partial comma");

	a_reset_holds: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		held |=> (r_q.state == ST_LOS) && !sync_acquired && err_level == CNT_ZERO)
		else $error("machine searched during digital reset");

	a_sync_stays: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(sync_acquired && !held && !(cg_valid && grp_bad)) |=> sync_acquired)
		else $error("sync dropped without an error group");

	a_err_floor: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(sync_acquired && err_level == CNT_ZERO && !(cg_valid && grp_bad))
		|=> err_level == CNT_ZERO)
		else $error("error count went below zero");

	a_err_clear_acq: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		$rose(sync_acquired) |-> err_level == CNT_ZERO)
		else $error("error count not cleared on acquire");

	// one errored group taken while in sync, the unit both loss and forgiving work on
	sequence s_bad_in_sync;
		sync_acquired && cg_valid && !held && grp_bad;
	endsequence

	// an errored group short of the limit is counted and sync holds
	a_err_counted: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		s_bad_in_sync ##0 (r_q.errs < CNT_W'(ERRS_N - CNT_ONE))
		|=> sync_acquired && err_level == CNT_W'($past(r_q.errs) + CNT_ONE))
		else $error("errored group not counted");

	// an errored group breaks the good run, so forgiving has to start over
	a_good_run_reset: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		s_bad_in_sync |=> r_q.good == CNT_ZERO)
		else $error("good run kept across an errored group");

	// every completed set moves the acquire count by exactly one
	a_sets_counted: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(r_q.state == ST_CDET && cg_valid && !held && data_ok)
		|=> r_q.sets == CNT_W'($past(r_q.sets) + CNT_ONE))
		else $error("sync set not counted");

	// a comma after an even run of data is misplaced and restarts the search
	a_odd_comma_lose: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(r_q.state == ST_ACQ && cg_valid && !held && is_comma && r_q.last_even)
		|=> r_q.state == ST_LOS)
		else $error("misplaced comma kept the search going");

	a_cdet_needs_data: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(r_q.state == ST_CDET && cg_valid && !held && !data_ok)
		|=> r_q.state == ST_LOS)
		else $error("comma without data was counted");

	// both disparities must match in either pattern length
	a_comma_both: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(pat_len_10 && (cg_raw == COMMA10_POS || cg_raw == COMMA10_NEG))
		|-> comma_hit)
		else $error("ten bit comma missed");

	a_comma_short: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(!pat_len_10 && (cg_raw[9:3] == COMMA7_POS || cg_raw[9:3] == COMMA7_NEG))
		|-> comma_hit)
		else $error("seven bit comma missed");

	// mode off behaves like digital reset, so nothing is searched for meanwhile
	a_mode_parks: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		!gbe_mode |=> !sync_acquired && err_level == CNT_ZERO)
		else $error("machine ran with the mode off");

	// sync can only come back through a final completed set
	a_low_until_acq: assert property (
		@(posedge ref_clk) disable iff (!arst_n)
		(!sync_acquired && r_q.state != ST_CDET) |=> !sync_acquired)
		else $error("sync rose without a final sync set");

endmodule

// ### verification/gbsm_link_model.sv
// remote transmitter model: one code group per send call
// assumes the bench calls send procedurally; groups change at the falling edge
`timescale 1ns/1ps
module gbsm_link_model
	import gbsm_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       short7,
	output logic            cg_valid,
	output logic [9:0]      cg_raw,
	output logic            cg_ctrl,
	output logic            cg_code_err
);
	logic rd_neg = 1'b0;
	initial begin
		cg_valid = 1'b0;
		cg_raw = 10'h000;
		cg_ctrl = 1'b0;
		cg_code_err = 1'b0;
	end
	// k: 0 idle, 1 comma, 2 data, 3 errored; idle inverts the line, only valid qualifies it
	task automatic send(input int k);
		@(negedge ref_clk);
		cg_valid    <= (k != 0);
		cg_ctrl     <= (k == 1);
		cg_code_err <= (k == 3);
		rd_neg      <= rd_neg ^ (k == 1);
		case (k)
		0: cg_raw <= ~cg_raw;
		1: cg_raw <= short7 ? {COMMA7_POS, 3'h5} : (rd_neg ? COMMA10_NEG : COMMA10_POS);
		default: cg_raw <= 10'h2A5;
		endcase
	endtask
endmodule

// ### verification/gbe_rx_sync_state_machine_test.sv
// self-checking bench for the receive sync machine
// assumes the link model stands in for the remote transmitter
`timescale 1ns/1ps
`define CHK(nm, e, s) check(nm, e, s)
module gbe_rx_sync_state_machine_test;
	import gbsm_pkg::*;
	logic             ref_clk;
	logic             arst_n;
	logic             rx_digitalreset;
	logic             gbe_mode;
	logic             pat_len_10;
	logic             short7;
	logic             cg_valid;
	logic [9:0]       cg_raw;
	logic             cg_ctrl;
	logic             cg_code_err;
	logic             sync_acquired;
	logic [CNT_W-1:0] err_level;
	int               n_mismatch = 0;
	int               checks_done = 0;
	always #50 ref_clk = ~ref_clk;
	gbsm_link_model lm (.ref_clk(ref_clk), .short7(short7), .cg_valid(cg_valid),
		.cg_raw(cg_raw), .cg_ctrl(cg_ctrl), .cg_code_err(cg_code_err));
	gbsm_sync DUT (.ref_clk(ref_clk), .arst_n(arst_n), .rx_digitalreset(rx_digitalreset),
		.gbe_mode(gbe_mode), .pat_len_10(pat_len_10), .cg_valid(cg_valid), .cg_raw(cg_raw),
		.cg_ctrl(cg_ctrl), .cg_code_err(cg_code_err), .sync_acquired(sync_acquired),
		.err_level(err_level));
	task automatic test_done();
		if (n_mismatch == 0 && checks_done > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task automatic check(input string nm, input logic [8:0] e, input logic [8:0] s);
		checks_done++;
		if (s !== e) begin
			n_mismatch++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// idle gaps let the registered outputs land before they are judged
	task automatic gap(input int n);
		repeat (n) lm.send(0);
	endtask
	task automatic sets(input int n);
		repeat (n) begin
			lm.send(1);
			lm.send(2);
		end
	endtask
	task automatic grp(input int k, input int n);
		repeat (n) lm.send(k);
	endtask
	// bounded wait; running out ends the run
	task automatic wait_sync(input logic e);
		for (int i = 0; i < 4 && sync_acquired !== e; i++) lm.send(0);
		`CHK("sync_wait", {8'h00, e}, {8'h00, sync_acquired});
		if (sync_acquired !== e)
			test_done();
	endtask
	task automatic dreset(input logic v);
		@(negedge ref_clk);
		rx_digitalreset = v;
	endtask
	task automatic t_acquire();
		sets(2);
		gap(3);
		`CHK("sync_early", 9'h000, {8'h00, sync_acquired});
		sets(1);
		wait_sync(1'b1);
		`CHK("err_clear", 9'h000, err_level);
	endtask
	task automatic t_lose();
		grp(3, 3);
		gap(2);
		`CHK("err_three", 9'h003, err_level);
		`CHK("sync_hold", 9'h001, {8'h00, sync_acquired});
		lm.send(3);
		wait_sync(1'b0);
		gap(4);
		`CHK("sync_low", 9'h000, {8'h00, sync_acquired});
	endtask
	task automatic t_forgive();
		grp(3, 2);
		grp(2, 4);
		gap(2);
		`CHK("err_dec", 9'h001, err_level);
		grp(2, 3);
		lm.send(3);
		grp(2, 3);
		gap(2);
		`CHK("err_run", 9'h002, err_level);
		grp(2, 13);
		gap(2);
		`CHK("err_floor", 9'h000, err_level);
	endtask
	task automatic t_reset();
		dreset(1'b1);
		gap(2);
		`CHK("sync_rst", 9'h000, {8'h00, sync_acquired});
		sets(3);
		gap(2);
		`CHK("sync_held", 9'h000, {8'h00, sync_acquired});
		dreset(1'b0);
		sets(3);
		wait_sync(1'b1);
	endtask
	task automatic t_short();
		short7 = 1'b1;
		sets(3);
		gap(3);
		`CHK("sync_10bit", 9'h000, {8'h00, sync_acquired});
		pat_len_10 = 1'b0;
		sets(3);
		wait_sync(1'b1);
		short7 = 1'b0;
		pat_len_10 = 1'b1;
	endtask
	task automatic t_odd();
		grp(1, 2);
		sets(1);
		lm.send(2);
		sets(3);
		gap(3);
		`CHK("sync_even", 9'h000, {8'h00, sync_acquired});
		sets(1);
		wait_sync(1'b1);
	endtask
	// mode off parks the machine; a mid-run async reset clears the count as well
	task automatic t_mode();
		lm.send(3);
		gap(2);
		`CHK("err_pre", 9'h001, err_level);
		@(negedge ref_clk);
		gbe_mode = 1'b0;
		gap(2);
		`CHK("sync_mode", 9'h000, {8'h00, sync_acquired});
		sets(3);
		gap(2);
		`CHK("sync_off", 9'h000, {8'h00, sync_acquired});
		@(negedge ref_clk);
		gbe_mode = 1'b1;
		sets(3);
		wait_sync(1'b1);
		lm.send(3);
		gap(1);
		@(negedge ref_clk);
		arst_n = 1'b0;
		gap(2);
		`CHK("err_arst", 9'h000, err_level);
		`CHK("sync_arst", 9'h000, {8'h00, sync_acquired});
		@(negedge ref_clk);
		arst_n = 1'b1;
		sets(3);
		wait_sync(1'b1);
	endtask
	// digital reset pulses put the machine back in loss of sync before t_short and before t_odd
	initial begin
		ref_clk = 1'b0;
		arst_n = 1'b0;
		rx_digitalreset = 1'b0;
		gbe_mode = 1'b1;
		pat_len_10 = 1'b1;
		short7 = 1'b0;
		repeat (6) @(negedge ref_clk);
		arst_n = 1'b1;
		t_acquire();
		t_lose();
		t_acquire();
		t_forgive();
		t_reset();
		dreset(1'b1);
		dreset(1'b0);
		t_short();
		dreset(1'b1);
		dreset(1'b0);
		t_odd();
		t_mode();
		test_done();
	end
endmodule
